// ---- design/ibc_pkg.sv ----
// shared constants, register map and carrier types of the bus interface
package ibc_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR0  = 8'h04;
   localparam logic [7:0] OFS_ADDR1  = 8'h08;
   localparam logic [7:0] OFS_ADDR2  = 8'h0C;
   localparam logic [7:0] OFS_DETECT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_MASK   = 8'h18;
   localparam logic [7:0] OFS_LINE   = 8'h1C;

   // field widths
   localparam int CTRL_W = 17;
   localparam int ADDR_W = 12;
   localparam int DET_W  = 3;
   localparam int STAT_W = 8;
   localparam int LINE_W = 3;
   localparam int DIV_W  = 7;

   // bus modes
   localparam logic [1:0] MODE_I2C   = 2'h0;
   localparam logic [1:0] MODE_SMBUS = 2'h1;
   localparam logic [1:0] MODE_FMP   = 2'h2;

   // timeout selections
   localparam logic [1:0] TOUT_OFF  = 2'h0;
   localparam logic [1:0] TOUT_LOW  = 2'h1;
   localparam logic [1:0] TOUT_HIGH = 2'h2;
   localparam logic [1:0] TOUT_BOTH = 2'h3;

   // own-address comparator formats
   localparam logic [1:0] FMT_OFF = 2'h0;
   localparam logic [1:0] FMT_7   = 2'h1;
   localparam logic [1:0] FMT_10  = 2'h2;

   // noise filter depth limit
   localparam logic [2:0] NF_MAX = 3'h4;

   // reserved address patterns and bit counter marks
   localparam logic [6:0] DEVID_ADDR  = 7'h7C;
   localparam logic [6:0] HOST_ADDR   = 7'h08;
   localparam logic [7:0] GCALL_BYTE  = 8'h00;
   localparam logic [4:0] TEN_PREFIX  = 5'h1E;
   localparam logic [3:0] BYTE_LAST   = 4'h7;
   localparam logic [3:0] ACK_SLOT    = 4'h8;

   // status bit positions
   localparam int ST_TOUT  = 0;
   localparam int ST_ARB   = 1;
   localparam int ST_HIT0  = 2;
   localparam int ST_GCALL = 5;
   localparam int ST_DEVID = 6;
   localparam int ST_HOST  = 7;

   // detection enable bit positions
   localparam int DET_GCALL = 0;
   localparam int DET_DEVID = 1;
   localparam int DET_HOST  = 2;

   // configuration word
   typedef struct packed {
      logic       sald;
      logic       ntald;
      logic [2:0] nf;
      logic       dly_div2;
      logic [2:0] dly;
      logic       tout_short;
      logic [1:0] tout_sel;
      logic [2:0] div;
      logic [1:0] mode;
   } ibc_ctrl_t;

   // own-address comparator setting
   typedef struct packed {
      logic [1:0] fmt;
      logic [9:0] addr;
   } ibc_addr_t;

   // address monitor states, gray along idle-first-second-data
   typedef enum logic [1:0] {
      MON_IDLE   = 2'h0,
      MON_FIRST  = 2'h1,
      MON_SECOND = 2'h3,
      MON_DATA   = 2'h2
   } ibc_mon_t;

endpackage : ibc_pkg

// ---- design/ibc_filter.sv ----
// synchroniser and programmable-depth noise filter for one bus line
module ibc_filter #(
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // line and settings
   input  wire logic       pin,
   input  wire logic       tick,
   input  wire logic [2:0] depth,
   // filtered level
   output logic            level
);

   logic             sync1;
   logic             sync2;
   logic [DEPTH-1:0] hist;

   // stage mask of the selected depth
   function automatic logic [DEPTH-1:0] stage_mask(input logic [2:0] d);
      stage_mask = DEPTH'((1 << d) - 1);
   endfunction : stage_mask

   // two flops before anything reads the pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
      end
      else
      begin
         sync1 <= pin;
         sync2 <= sync1;
      end
   end

   // history sampled on the reference tick only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hist <= '1;
      else if (tick)
         hist <= {hist[DEPTH-2:0], sync2};
   end

   // level only moves once every selected stage agrees
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level <= 1'b1;
      else if (depth == 3'h0)
         level <= sync2;
      else if ((hist & stage_mask(depth)) == stage_mask(depth))
         level <= 1'b1;
      else if ((hist & stage_mask(depth)) == '0)
         level <= 1'b0;
   end

endmodule : ibc_filter

// ---- design/ibc_config.sv ----
// configuration, line monitor and address recognition of the bus interface
//
// Functional notes
// - Bus mode is I2C or SMBus; fast-mode-plus only on channel zero.
// - Reference clock is the bus clock divided by 1 to 128.
// - Timeout off, or clock stuck low, stuck high, or either level.
// - Timeout counter runs long with 16 bits or short with 14 bits.
// - Data output changes are delayed zero to seven delay ticks.
// - Delay counter ticks on the reference clock or every second tick.
// - Input noise filter bypassed or one to four stages deep.
// - Optional arbitration loss on ACK seen while sending NACK.
// - Optional arbitration loss on slave transmit bit mismatch.
// - Three own-address comparators, each off, 7-bit or 10-bit.
// - General call address is recognised only when enabled.
// - Device-ID address after a start recognised when enabled.
// - SMBus host address recognised when enabled in SMBus mode.
// - A disabled comparator's address value never causes a match.
module ibc_config #(
   parameter int CHANNEL      = 0,
   parameter int TOUT_LONG_W  = 16,
   parameter int TOUT_SHORT_W = 14,
   parameter int NF_DEPTH     = 4
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   // protocol engine side
   input  wire logic        engine_sda,
   input  wire logic        engine_nack_tx,
   input  wire logic        engine_slave_tx,
   output logic [1:0]       bus_mode,
   output logic             ref_tick,
   output logic             scl_level,
   output logic             sda_level,
   output logic             addr_match,
   output logic [5:0]       match_id,
   output logic             arb_lost,
   output logic             timeout,
   // interrupt
   output logic             irq
);

   ibc_pkg::ibc_ctrl_t          ctrl;
   ibc_pkg::ibc_addr_t          acfg [3];
   logic [ibc_pkg::DET_W-1:0]   det_en;
   logic [ibc_pkg::STAT_W-1:0]  status;
   logic [ibc_pkg::STAT_W-1:0]  mask;
   logic [ibc_pkg::DIV_W-1:0]   div_cnt;
   logic [TOUT_LONG_W-1:0]      tout_cnt;
   logic                        tout_fired;
   logic                        scl_q;
   logic                        sda_q;
   logic                        scl_f;
   logic                        sda_f;
   ibc_pkg::ibc_mon_t           mon;
   logic [3:0]                  bit_cnt;
   logic [7:0]                  shreg;
   logic [2:0]                  pend10;
   logic                        dly_target;
   logic                        dly_busy;
   logic [2:0]                  dly_cnt;
   logic                        dly_half;
   logic [31:0]                 next_prdata;
   logic                        next_pslverr;
   logic [ibc_pkg::STAT_W-1:0]  evt;
   logic [5:0]                  next_hit;
   logic [2:0]                  next_pend;
   logic [7:0]                  next_byte;

   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pready & pwrite;
   wire start_c   = scl_f & scl_q & sda_q & ~sda_f;
   wire stop_c    = scl_f & scl_q & ~sda_q & sda_f;
   wire scl_rise  = scl_f & ~scl_q;
   wire byte_done = scl_rise & (bit_cnt == ibc_pkg::BYTE_LAST)
                    & ((mon == ibc_pkg::MON_FIRST)
                       | (mon == ibc_pkg::MON_SECOND));
   wire dly_tick  = ref_tick & (~ctrl.dly_div2 | dly_half);

   // select mask of the reference divider
   function automatic logic [ibc_pkg::DIV_W-1:0] div_mask(
      input logic [2:0] d);
      div_mask = ibc_pkg::DIV_W'((1 << d) - 1);
   endfunction : div_mask

   // legal configuration: fast-mode-plus only on channel zero
   function automatic ibc_pkg::ibc_ctrl_t legal_ctrl(
      input logic [ibc_pkg::CTRL_W-1:0] w);
      ibc_pkg::ibc_ctrl_t c;
      c = ibc_pkg::ibc_ctrl_t'(w);
      if ((c.mode == ibc_pkg::MODE_FMP && CHANNEL != 0)
          || (c.mode > ibc_pkg::MODE_FMP))
         c.mode = ibc_pkg::MODE_I2C;
      if (c.nf > ibc_pkg::NF_MAX)
         c.nf = ibc_pkg::NF_MAX;
      legal_ctrl = c;
   endfunction : legal_ctrl

   // apb access phase is always one cycle long
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= apb_setup;
         prdata  <= apb_setup ? next_prdata : 32'h0000_0000;
         pslverr <= apb_setup & next_pslverr;
      end
   end

   // read mux, unmapped addresses answer with an error and zero
   always_comb
   begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (paddr)
         ibc_pkg::OFS_CTRL:   next_prdata = 32'(ctrl);
         ibc_pkg::OFS_ADDR0:  next_prdata = 32'(acfg[0]);
         ibc_pkg::OFS_ADDR1:  next_prdata = 32'(acfg[1]);
         ibc_pkg::OFS_ADDR2:  next_prdata = 32'(acfg[2]);
         ibc_pkg::OFS_DETECT: next_prdata = 32'(det_en);
         ibc_pkg::OFS_STATUS: next_prdata = 32'(status);
         ibc_pkg::OFS_MASK:   next_prdata = 32'(mask);
         ibc_pkg::OFS_LINE:   next_prdata = 32'({mon != ibc_pkg::MON_IDLE,
                                                  sda_f, scl_f});
         default:             next_pslverr = 1'b1;
      endcase
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl   <= '0;
         acfg   <= '{default: '0};
         det_en <= '0;
         mask   <= '0;
      end
      else if (apb_wr)
      begin
         case (paddr)
            ibc_pkg::OFS_CTRL:
               ctrl <= legal_ctrl(pwdata[ibc_pkg::CTRL_W-1:0]);
            ibc_pkg::OFS_ADDR0:  acfg[0] <= pwdata[ibc_pkg::ADDR_W-1:0];
            ibc_pkg::OFS_ADDR1:  acfg[1] <= pwdata[ibc_pkg::ADDR_W-1:0];
            ibc_pkg::OFS_ADDR2:  acfg[2] <= pwdata[ibc_pkg::ADDR_W-1:0];
            ibc_pkg::OFS_DETECT: det_en  <= pwdata[ibc_pkg::DET_W-1:0];
            ibc_pkg::OFS_MASK:   mask    <= pwdata[ibc_pkg::STAT_W-1:0];
            default:             mask    <= mask;
         endcase
      end
   end

   assign bus_mode = ctrl.mode;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status <= '0;
      else if (apb_wr && paddr == ibc_pkg::OFS_STATUS)
         status <= (status & ~pwdata[ibc_pkg::STAT_W-1:0]) | evt;
      else
         status <= status | evt;
   end

   // level interrupt from unmasked status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(status & mask);
   end

   // reference clock as a one-cycle tick every 2^div bus clocks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt  <= '0;
         ref_tick <= 1'b0;
      end
      else
      begin
         div_cnt  <= div_cnt + 1'b1;
         ref_tick <= (div_cnt & div_mask(ctrl.div))
                     == div_mask(ctrl.div);
      end
   end

   // line filters; the pins are synchronised inside
   ibc_filter #(.DEPTH(NF_DEPTH)) u_scl_filter (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (scl_in),
      .tick    (ref_tick),
      .depth   (ctrl.nf),
      .level   (scl_f)
   );

   ibc_filter #(.DEPTH(NF_DEPTH)) u_sda_filter (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (sda_in),
      .tick    (ref_tick),
      .depth   (ctrl.nf),
      .level   (sda_f)
   );

   // previous filtered levels for edge and condition detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign scl_level = scl_q;
   assign sda_level = sda_q;

   // stuck clock timeout; counts reference ticks, restarts on any edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tout_cnt   <= '0;
         tout_fired <= 1'b0;
      end
      else if (scl_f != scl_q || ctrl.tout_sel == ibc_pkg::TOUT_OFF)
      begin
         tout_cnt   <= '0;
         tout_fired <= 1'b0;
      end
      else if (ref_tick && !tout_fired
               && (ctrl.tout_sel == ibc_pkg::TOUT_BOTH
                   || (ctrl.tout_sel == ibc_pkg::TOUT_LOW && !scl_f)
                   || (ctrl.tout_sel == ibc_pkg::TOUT_HIGH && scl_f)))
      begin
         tout_cnt <= tout_cnt + 1'b1;
         if (tout_cnt == ({TOUT_LONG_W{1'b1}}
                          >> (ctrl.tout_short ?
                              TOUT_LONG_W - TOUT_SHORT_W : 0)))
            tout_fired <= 1'b1;
      end
   end

   // one pulse per stuck period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timeout <= 1'b0;
      else
         timeout <= evt[ibc_pkg::ST_TOUT];
   end

   // arbitration loss is judged where the bus samples data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         arb_lost <= 1'b0;
      else
         arb_lost <= evt[ibc_pkg::ST_ARB];
   end

   // address compare on the byte being completed
   always_comb
   begin
      next_byte = {shreg[6:0], sda_f};
      next_hit  = '0;
      next_pend = '0;
      for (int i = 0; i < 3; i++)
      begin
         if (mon == ibc_pkg::MON_FIRST)
         begin
            if (acfg[i].fmt == ibc_pkg::FMT_7
                && next_byte[7:1] == acfg[i].addr[6:0])
               next_hit[i] = 1'b1;
            if (acfg[i].fmt == ibc_pkg::FMT_10
                && next_byte[7:3] == ibc_pkg::TEN_PREFIX
                && next_byte[2:1] == acfg[i].addr[9:8])
               next_pend[i] = 1'b1;
         end
         else if (pend10[i] && acfg[i].fmt == ibc_pkg::FMT_10
                  && next_byte == acfg[i].addr[7:0])
            next_hit[i] = 1'b1;
      end
      if (mon == ibc_pkg::MON_FIRST)
      begin
         next_hit[3] = det_en[ibc_pkg::DET_GCALL]
                       & (next_byte == ibc_pkg::GCALL_BYTE);
         next_hit[4] = det_en[ibc_pkg::DET_DEVID]
                       & (next_byte[7:1] == ibc_pkg::DEVID_ADDR);
         next_hit[5] = det_en[ibc_pkg::DET_HOST]
                       & (ctrl.mode == ibc_pkg::MODE_SMBUS)
                       & (next_byte[7:1] == ibc_pkg::HOST_ADDR);
      end
   end

   // event vector feeding the sticky status
   always_comb
   begin
      evt = '0;
      evt[ibc_pkg::ST_TOUT] = ref_tick & ~tout_fired & ~(scl_f != scl_q)
                              & (ctrl.tout_sel != ibc_pkg::TOUT_OFF)
                              & (ctrl.tout_sel == ibc_pkg::TOUT_BOTH
                                 | (ctrl.tout_sel == ibc_pkg::TOUT_LOW
                                    & ~scl_f)
                                 | (ctrl.tout_sel == ibc_pkg::TOUT_HIGH
                                    & scl_f))
                              & (tout_cnt == ({TOUT_LONG_W{1'b1}}
                                 >> (ctrl.tout_short ?
                                     TOUT_LONG_W - TOUT_SHORT_W : 0)));
      evt[ibc_pkg::ST_ARB]  = scl_rise & ~sda_f
                              & ((ctrl.ntald & engine_nack_tx)
                                 | (ctrl.sald & engine_slave_tx
                                    & engine_sda));
      if (byte_done)
         evt[ibc_pkg::ST_HOST:ibc_pkg::ST_HIT0] = next_hit;
   end

   // byte framing after every start, repeated starts included
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mon     <= ibc_pkg::MON_IDLE;
         bit_cnt <= '0;
         shreg   <= '0;
         pend10  <= '0;
      end
      else if (start_c)
      begin
         mon     <= ibc_pkg::MON_FIRST;
         bit_cnt <= '0;
         pend10  <= '0;
      end
      else if (stop_c)
         mon <= ibc_pkg::MON_IDLE;
      else if (scl_rise && mon != ibc_pkg::MON_IDLE)
      begin
         if (bit_cnt == ibc_pkg::ACK_SLOT)
            bit_cnt <= '0;
         else
         begin
            bit_cnt <= bit_cnt + 1'b1;
            shreg   <= next_byte;
         end
         if (byte_done)
         begin
            case (mon)
               ibc_pkg::MON_FIRST:
               begin
                  pend10 <= next_pend;
                  mon    <= (|next_pend) ? ibc_pkg::MON_SECOND
                                         : ibc_pkg::MON_DATA;
               end
               ibc_pkg::MON_SECOND: mon <= ibc_pkg::MON_DATA;
               default:             mon <= ibc_pkg::MON_IDLE;
            endcase
         end
      end
   end

   // match report towards the protocol engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_match <= 1'b0;
         match_id   <= '0;
      end
      else
      begin
         addr_match <= byte_done & (|next_hit);
         if (byte_done && |next_hit)
            match_id <= next_hit;
      end
   end

   // output delay, restarted by every new engine level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dly_target <= 1'b1;
         dly_busy   <= 1'b0;
         dly_cnt    <= '0;
         sda_oe_n   <= 1'b1;
      end
      else if (engine_sda != dly_target)
      begin
         dly_target <= engine_sda;
         dly_cnt    <= ctrl.dly;
         dly_busy   <= 1'b1;
      end
      else if (dly_busy)
      begin
         if (dly_cnt == 3'h0)
         begin
            sda_oe_n <= dly_target;
            dly_busy <= 1'b0;
         end
         else if (dly_tick)
            dly_cnt <= dly_cnt - 1'b1;
      end
   end

   // halves the delay tick rate when the divide-by-two source is chosen
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dly_half <= 1'b0;
         sda_out  <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0;                             // open drain, low only
         if (ref_tick)
            dly_half <= ~dly_half;
      end
   end

endmodule : ibc_config

// ---- testbench/ibc_monitor.sv ----
// concurrent checks on the bus interface configuration ports
module ibc_monitor (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // line side
   input wire logic        sda_oe_n,
   input wire logic        engine_sda,
   input wire logic        engine_nack_tx,
   input wire logic        engine_slave_tx,
   input wire logic [1:0]  bus_mode,
   input wire logic        scl_level,
   input wire logic        addr_match,
   input wire logic        arb_lost,
   input wire logic        timeout
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // one wait-free access cycle after every setup
   property p_rdy;
      psel && !penable |=> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rdy1;
      pready |=> !pready;
   endproperty
   a_rdy1: assert property (p_rdy1) else $error("ready held too long");
   property p_err;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("stray slave error");
   property p_rd0;
      !pready |-> prdata == 32'h0;
   endproperty
   a_rd0: assert property (p_rd0) else $error("read data outside access");
   property p_mode;
      bus_mode != 2'h3;
   endproperty
   a_mode: assert property (p_mode)
      else $error("illegal mode");
   // a finished delay always shows the engine level of two edges before
   property p_oe;
      $changed(sda_oe_n) |-> sda_oe_n == $past(engine_sda, 2);
   endproperty
   a_oe: assert property (p_oe)
      else $error("sda out of step");
   property p_arb;
      arb_lost |-> $past(engine_nack_tx) || $past(engine_slave_tx);
   endproperty
   a_arb: assert property (p_arb)
      else $error("arb lost no cause");
   property p_tout;
      timeout |-> $stable(scl_level) ##1 !timeout;
   endproperty
   a_tout: assert property (p_tout)
      else $error("bad timeout");
   property p_hit;
      addr_match |=> !addr_match;
   endproperty
   a_hit: assert property (p_hit)
      else $error("match not a pulse");
endmodule : ibc_monitor

bind ibc_config ibc_monitor mon_u (.*);

// ---- testbench/ibc_bus_master.sv ----
// far-side bus master: frames on released-high open-drain lines
module ibc_bus_master (
   // lines, 1 means released to the pull-up
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   initial scl = 1'b1;
   initial sda = 1'b1;
   // start, n bytes msb first with ack slot released, stop
   task send(input logic [15:0] b, input int n);
      sda = 1'b0;
      #62.5;
      for (int i = 0; i < 9 * n; i++)
      begin
         scl = 1'b0;
         #31.25;
         sda = (i % 9 == 8) ? 1'b1 : b[15 - 8 * (i / 9) - i % 9];
         #31.25;
         scl = 1'b1;
         #62.5;
      end
      scl = 1'b0;
      #31.25;
      sda = 1'b0;
      #31.25;
      scl = 1'b1;
      #62.5;
      sda = 1'b1;
      #62.5;
   endtask : send
   // clock line held low, as a stuck bus
   task stick(input int t);
      scl = 1'b0;
      #(t);
      scl = 1'b1;
   endtask : stick
endmodule : ibc_bus_master

// ---- testbench/testbench.sv ----
// self-checking bench for the bus interface configuration block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] CT = ibc_pkg::OFS_CTRL;
   localparam logic [7:0] ST = ibc_pkg::OFS_STATUS;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, esda = 1'b1, enack = 1'b0;
   logic        estx = 1'b0, scl_lv, sda_lv;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic        pready, pslverr, ev, sda_out, sda_oe_n, m_scl, m_sda;
   logic        ref_tick, addr_match, arb_lost, timeout, irq;
   logic [1:0]  bus_mode;
   logic [5:0]  match_id;
   wire logic   sda_w;
   int          bad_count = 0, checked = 0, k, n_hit = 0, n_arb = 0;
   int          n_tout = 0;

   always #4 pclk = ~pclk;

   // one-cycle pulses counted where they have settled
   always @(negedge pclk)
   begin
      n_hit  += (addr_match === 1'b1);
      n_arb  += (arb_lost === 1'b1);
      n_tout += (timeout === 1'b1);
   end
   // open drain: whoever pulls low wins over the pull-up
   assign sda_w = m_sda & (sda_oe_n | sda_out);

   ibc_bus_master bus_u (.scl(m_scl), .sda(m_sda));
   ibc_config #(.TOUT_LONG_W(6), .TOUT_SHORT_W(4)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(m_scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .engine_sda(esda),
      .engine_nack_tx(enack), .engine_slave_tx(estx),
      .bus_mode(bus_mode), .ref_tick(ref_tick), .scl_level(scl_lv),
      .sda_level(sda_lv), .addr_match(addr_match), .match_id(match_id),
      .arb_lost(arb_lost), .timeout(timeout), .irq(irq));

   task end_sim;
      $display("errors %0d checks %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task chk(input string n, input logic [31:0] e, input logic [31:0] a);
      checked++;
      if (a !== e)
      begin
         bad_count++;
         $display("wrong value %s exp %h got %h", n, e, a);
      end
   endtask : chk

   // one apb transfer; data taken where pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
      if (pready !== 1'b1)
      begin
         bad_count++;
         end_sim();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rc(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, rv);
   endtask : rc

   // one frame, then status and irq, then clear by writing ones
   task hit(input logic [15:0] b, input int n, input logic [31:0] e);
      bus_u.send(b, n);
      rc(ST, e, "status");
      chk("irq", {31'h0, e != 32'h0}, {31'h0, irq});
      apb(1'b1, ST, 32'hFF);
   endtask : hit

   // new engine level, then negedges until the pad enable follows it
   task dly_run(input logic [31:0] cv, input logic v);
      apb(1'b1, CT, cv);
      esda <= v;
      k = 0;
      while (sda_oe_n !== v && k < 20)
      begin
         @(negedge pclk);
         k++;
      end
   endtask : dly_run

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rc(CT, 32'h0, "ctrl");
      rc(ibc_pkg::OFS_LINE, 32'h3, "line");
      chk("levels", 32'h3, {29'h0, sda_out, sda_lv, scl_lv});
      rc(8'h20, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, ev});
      apb(1'b1, CT, 32'h7003);
      rc(CT, 32'h4000, "ctrl clip");
      apb(1'b1, CT, 32'h0002);
      rc(CT, 32'h0002, "fast plus");
      apb(1'b1, CT, 32'h100C);
      // skip the one tick still launched under the old divider
      @(posedge pclk);
      k = 0;
      repeat (64) @(negedge pclk) k += (ref_tick === 1'b1);
      chk("ticks", 32'h8, k);
      apb(1'b1, CT, 32'h1000);
      apb(1'b1, ibc_pkg::OFS_MASK, 32'hFE);
      apb(1'b1, ibc_pkg::OFS_ADDR0, 32'h455);
      apb(1'b1, ibc_pkg::OFS_ADDR1, 32'h033);
      apb(1'b1, ibc_pkg::OFS_ADDR2, 32'hAA5);
      apb(1'b1, ibc_pkg::OFS_DETECT, 32'h7);
      hit(16'hAA00, 1, 32'h04);
      chk("match id", 32'h01, {26'h0, match_id});
      hit(16'h6600, 1, 32'h00);
      hit(16'hF4A5, 2, 32'h10);
      hit(16'h0000, 1, 32'h20);
      hit(16'hF900, 1, 32'h40);
      hit(16'h1000, 1, 32'h00);
      apb(1'b1, CT, 32'h1001);
      hit(16'h1000, 1, 32'h80);
      chk("bus mode", 32'h1, {30'h0, bus_mode});
      apb(1'b1, ibc_pkg::OFS_DETECT, 32'h0);
      hit(16'h0000, 1, 32'h00);
      apb(1'b1, CT, 32'h9000);
      enack <= 1'b1;
      hit(16'h0000, 1, 32'h02);
      enack <= 1'b0;
      apb(1'b1, CT, 32'h11000);
      estx <= 1'b1;
      hit(16'h0000, 1, 32'h02);
      estx <= 1'b0;
      // short count only: the long one would not expire in this hold
      apb(1'b1, CT, 32'h10A0);
      bus_u.stick(400);
      rc(ST, 32'h01, "timeout");
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(1'b1, ibc_pkg::OFS_MASK, 32'hFF);
      rc(ibc_pkg::OFS_MASK, 32'hFF, "mask");
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, ST, 32'h01);
      rc(ST, 32'h0, "cleared");
      chk("irq off", 32'h0, {31'h0, irq});
      // zero delay, three plain ticks, three halved ticks of either phase
      dly_run(32'h1000, 1'b0);
      chk("sda delay", 32'h3, k);
      dly_run(32'h1300, 1'b1);
      chk("sda delay 3", 32'h6, k);
      dly_run(32'h1B00, 1'b0);
      chk("sda delay half", 32'h8, k & ~32'h1);
      chk("match pulses", 32'h5, n_hit);
      chk("arb pulses", 32'h12, n_arb);
      chk("timeout pulses", 32'h1, n_tout);
      end_sim();
   end
endmodule : testbench
